// >>> include/mpt_defines.vh
`ifndef MPT_DEFINES_VH
`define MPT_DEFINES_VH

// Register byte addresses
`define MPT_ADDR_MCTRL    8'h00
`define MPT_ADDR_SWRST    8'h04
`define MPT_ADDR_STATUS   8'h08
`define MPT_ADDR_CLEAR    8'h0c
`define MPT_ADDR_IRQEN    8'h10
`define MPT_ADDR_ID       8'h14
`define MPT_ADDR_CH_BASE  8'h20
`define MPT_CH_STRIDE     8'h10
`define MPT_CH_PERIOD     2'h0
`define MPT_CH_COUNT      2'h1
`define MPT_CH_CTRL       2'h2
`define MPT_CH_CAPTURE    2'h3

// Module control fields
`define MPT_MC_DEBUG_BIT  0
`define MPT_MC_DOZE_BIT   1
`define MPT_MC_EN_BIT     2

// Channel control fields
`define MPT_CC_RUN_BIT    0
`define MPT_CC_MODE_LO    1
`define MPT_CC_CHAIN_BIT  3
`define MPT_CC_SRC_BIT    4
`define MPT_CC_HALT_BIT   5
`define MPT_CC_START_BIT  6
`define MPT_CC_RELOAD_BIT 7
`define MPT_CC_SEL_LO     8
`define MPT_CC_WIDTH      12

// Modes
`define MPT_MODE_FULL     2'h0
`define MPT_MODE_SPLIT    2'h1
`define MPT_MODE_TRIG     2'h2
`define MPT_MODE_CAPT     2'h3

// Reset values and the capture-mode load value
`define MPT_RST_MCTRL     3'h0
`define MPT_RST_WORD      32'h00000000
`define MPT_ALL_ONES      32'hffffffff

// Settle time after reset or enable change, in ns (functional clock of 10 ns)
`define MPT_SETTLE_NS     40
`define MPT_CLK_NS        10
`define MPT_SETTLE_CYC    ((`MPT_SETTLE_NS + `MPT_CLK_NS - 1) / `MPT_CLK_NS)

`endif

// >>> verilog/mpt_trig_sel.v
`timescale 1ns/1ns
`default_nettype none
module mpt_trig_sel #(
   parameter NSRC = 16
) (
   input wire clk, // Clock
   input wire rst_b, // Async reset, low
   input wire sw_clr, // Software reset pulse
   input wire [NSRC-1:0] int_trig, // Channel outputs
   input wire [NSRC-1:0] ext_trig, // External trigger inputs
   input wire [3:0] sel, // Trigger select
   input wire src_int, // 1 selects internal
   output reg trig_edge // One-cycle rising edge
);
   reg last;
   wire picked = src_int ? int_trig[sel] : ext_trig[sel];
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last <= 1'b0;
         trig_edge <= 1'b0;
      end else if (sw_clr) begin
         last <= 1'b0;
         trig_edge <= 1'b0;
      end else begin
         last <= picked;
         trig_edge <= picked & ~last;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/mpt_chan.v
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.vh"
module mpt_chan (
   input wire clk, // Clock
   input wire rst_b, // Async reset, low
   input wire sw_clr, // Software reset pulse
   input wire halt, // Debug or doze freeze
   input wire [`MPT_CC_WIDTH-1:0] ctrl, // Channel control
   input wire [31:0] period_value, // Programmed period
   input wire trig, // Trigger edge
   input wire prev_expire, // Previous channel expiry
   output reg [31:0] count, // Current count
   output reg [31:0] capture, // Captured inverse
   output reg expire, // One-cycle expiry pulse
   output reg pre_trig, // Output pre-trigger
   output reg running // Counter active
);
   wire run_en = ctrl[`MPT_CC_RUN_BIT];
   wire [1:0] mode = ctrl[`MPT_CC_MODE_LO+1:`MPT_CC_MODE_LO];
   wire chain = ctrl[`MPT_CC_CHAIN_BIT];
   wire halt_exp = ctrl[`MPT_CC_HALT_BIT];
   wire start_trig = ctrl[`MPT_CC_START_BIT];
   wire reload_trig = ctrl[`MPT_CC_RELOAD_BIT];
   reg armed;
   reg stopped;
   reg run_q;
   wire tick = chain ? prev_expire : 1'b1;
   wire step = (mode == `MPT_MODE_TRIG) ? trig : tick;
   wire [31:0] load_val = (mode == `MPT_MODE_CAPT) ? `MPT_ALL_ONES : period_value;
   wire lo_zero = (count[15:0] == 16'h0000);
   wire done = (mode == `MPT_MODE_SPLIT) ? (lo_zero && count[31:16] == 16'h0000) : (count == `MPT_RST_WORD);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= `MPT_RST_WORD;
         capture <= `MPT_RST_WORD;
         expire <= 1'b0;
         pre_trig <= 1'b0;
         running <= 1'b0;
         armed <= 1'b0;
         stopped <= 1'b0;
         run_q <= 1'b0;
      end else if (sw_clr) begin
         count <= `MPT_RST_WORD;
         capture <= `MPT_RST_WORD;
         expire <= 1'b0;
         pre_trig <= 1'b0;
         running <= 1'b0;
         armed <= 1'b0;
         stopped <= 1'b0;
         run_q <= 1'b0;
      end else begin
         run_q <= run_en;
         expire <= 1'b0;
         if (!run_en) begin
            running <= 1'b0;
            armed <= 1'b0;
            stopped <= 1'b0;
            pre_trig <= 1'b0;
         end else if (!run_q) begin
            count <= load_val;
            armed <= ~(start_trig | mode == `MPT_MODE_TRIG);
            running <= 1'b1;
         end else if (!armed) begin
            if (trig) begin
               armed <= 1'b1;
               count <= load_val;
            end
         end else if (stopped) begin
            running <= 1'b0;
         end else if (reload_trig && trig && mode != `MPT_MODE_TRIG) begin
            count <= load_val;
            pre_trig <= 1'b0;
         end else if (!halt) begin
            if (mode == `MPT_MODE_CAPT && trig)
               capture <= ~count;
            if (step) begin
               if (done) begin
                  expire <= 1'b1;
                  pre_trig <= 1'b0;
                  count <= load_val;
                  if (halt_exp) stopped <= 1'b1;
               end else if (mode == `MPT_MODE_SPLIT) begin
                  if (!lo_zero) begin
                     count[15:0] <= count[15:0] - 16'h0001;
                     if (count[15:0] == 16'h0001) pre_trig <= 1'b1;
                  end else begin
                     count[31:16] <= count[31:16] - 16'h0001;
                  end
               end else begin
                  count <= count - 32'h00000001;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/mpt_timer.v
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.vh"
module mpt_timer #(
   parameter NCH = 4,
   parameter NSRC = 16,
   parameter [31:0] ID_VALUE = 32'h0000a5a5 // Arbitrary identity value
) (
   input wire clk, // 100 MHz clock
   input wire rst_b, // Async reset, low
   input wire [7:0] addr, // Register byte address
   input wire [31:0] wdata, // Write data
   input wire wr, // Write strobe
   input wire rd, // Read strobe
   output reg [31:0] rdata, // Read data, cycle after rd
   input wire [NSRC-1:0] ext_trig, // External triggers
   input wire debug_mode, // Processor halted in debug
   input wire doze_mode, // Processor in doze
   output reg [NCH-1:0] chan_trig, // Channel expiry pulses
   output reg [NCH-1:0] chan_pre, // Channel pre-triggers
   output reg irq // Interrupt level
);
   reg [2:0] mctrl;
   reg [NCH-1:0] flags;
   reg [NCH-1:0] irq_en;
   reg [`MPT_CC_WIDTH-1:0] ctrl [0:NCH-1];
   reg [31:0] period [0:NCH-1];
   reg sw_clr;
   wire [31:0] count [0:NCH-1];
   wire [31:0] capt [0:NCH-1];
   wire [NCH-1:0] expire;
   wire [NCH-1:0] pre;
   wire [NCH-1:0] running;
   wire [NCH-1:0] trig;
   wire [NSRC-1:0] int_lines;

   wire halt = (debug_mode & ~mctrl[`MPT_MC_DEBUG_BIT]) | (doze_mode & ~mctrl[`MPT_MC_DOZE_BIT]);
   wire mod_en = mctrl[`MPT_MC_EN_BIT];

   // Channel register slot and field of an address
   function is_chan;
      input [7:0] a;
      begin
         is_chan = (a >= `MPT_ADDR_CH_BASE) && (a < `MPT_ADDR_CH_BASE + NCH * `MPT_CH_STRIDE) && (a[1:0] == 2'b00);
      end
   endfunction

   function [7:0] chan_idx;
      input [7:0] a;
      reg [7:0] off;
      begin
         off = a - `MPT_ADDR_CH_BASE;
         chan_idx = {4'h0, off[7:4]};
      end
   endfunction

   assign int_lines = {{(NSRC-NCH){1'b0}}, chan_trig};

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gch
         wire [`MPT_CC_WIDTH-1:0] eff_ctrl = mod_en ? ctrl[g] : {ctrl[g][`MPT_CC_WIDTH-1:1], 1'b0};
         wire prev_exp;
         if (g == 0) begin : gfirst
            assign prev_exp = 1'b0;
         end else begin : gnext
            assign prev_exp = expire[g-1];
         end
         mpt_trig_sel #(.NSRC(NSRC)) u_sel (
            .clk(clk),
            .rst_b(rst_b),
            .sw_clr(sw_clr),
            .int_trig(int_lines),
            .ext_trig(ext_trig),
            .sel(ctrl[g][`MPT_CC_SEL_LO+3:`MPT_CC_SEL_LO]),
            .src_int(ctrl[g][`MPT_CC_SRC_BIT]),
            .trig_edge(trig[g])
         );
         mpt_chan u_chan (
            .clk(clk),
            .rst_b(rst_b),
            .sw_clr(sw_clr),
            .halt(halt),
            .ctrl(eff_ctrl),
            .period_value(period[g]),
            .trig(trig[g]),
            .prev_expire(prev_exp),
            .count(count[g]),
            .capture(capt[g]),
            .expire(expire[g]),
            .pre_trig(pre[g]),
            .running(running[g])
         );
      end
   endgenerate

   integer i;
   wire [7:0] ci = chan_idx(addr);
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mctrl <= `MPT_RST_MCTRL;
         flags <= {NCH{1'b0}};
         irq_en <= {NCH{1'b0}};
         sw_clr <= 1'b0;
         chan_trig <= {NCH{1'b0}};
         chan_pre <= {NCH{1'b0}};
         irq <= 1'b0;
         for (i = 0; i < NCH; i = i + 1) begin
            ctrl[i] <= {`MPT_CC_WIDTH{1'b0}};
            period[i] <= `MPT_RST_WORD;
         end
      end else begin
         sw_clr <= wr && addr == `MPT_ADDR_SWRST && wdata[0];
         chan_trig <= expire;
         chan_pre <= pre;
         irq <= |(flags & irq_en);
         if (sw_clr) begin
            flags <= {NCH{1'b0}};
            irq_en <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
               ctrl[i] <= {`MPT_CC_WIDTH{1'b0}};
               period[i] <= `MPT_RST_WORD;
            end
         end else begin
            flags <= (flags & ~((wr && addr == `MPT_ADDR_CLEAR) ? wdata[NCH-1:0] : {NCH{1'b0}})) | expire;
            if (wr && addr == `MPT_ADDR_IRQEN)
               irq_en <= wdata[NCH-1:0];
            if (wr && is_chan(addr) && addr[3:2] == `MPT_CH_PERIOD)
               period[ci[1:0]] <= wdata;
            if (wr && is_chan(addr) && addr[3:2] == `MPT_CH_CTRL)
               ctrl[ci[1:0]] <= wdata[`MPT_CC_WIDTH-1:0];
         end
         if (wr && addr == `MPT_ADDR_MCTRL)
            mctrl <= wdata[2:0];
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `MPT_RST_WORD;
      end else if (rd) begin
         if (addr == `MPT_ADDR_MCTRL)
            rdata <= {29'h0, mctrl};
         else if (addr == `MPT_ADDR_STATUS)
            rdata <= {{(32-NCH){1'b0}}, flags};
         else if (addr == `MPT_ADDR_IRQEN)
            rdata <= {{(32-NCH){1'b0}}, irq_en};
         else if (addr == `MPT_ADDR_ID)
            rdata <= ID_VALUE;
         else if (is_chan(addr)) begin
            case (addr[3:2])
               `MPT_CH_PERIOD: rdata <= period[ci[1:0]];
               `MPT_CH_COUNT: rdata <= count[ci[1:0]];
               `MPT_CH_CTRL: rdata <= {19'h0, running[ci[1:0]], ctrl[ci[1:0]]};
               default: rdata <= capt[ci[1:0]];
            endcase
         end else
            rdata <= `MPT_RST_WORD;
      end else begin
         rdata <= `MPT_RST_WORD;
      end
   end
endmodule
`default_nettype wire

// >>> verif/mpt_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.vh"
module mpt_sva #(
   parameter NCH = 4,
   parameter NSRC = 16,
   parameter [31:0] ID_VALUE = 32'h0000a5a5 // Arbitrary value
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [NSRC-1:0] ext_trig,
   input wire logic debug_mode,
   input wire logic doze_mode,
   input wire logic [NCH-1:0] chan_trig,
   input wire logic [NCH-1:0] chan_pre,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data without read");
   hole_read_a: assert property (rd && addr == 8'hfc |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   id_read_a: assert property (rd && addr == `MPT_ADDR_ID |=> rdata == ID_VALUE)
      else $error("identity read wrong");
   swreset_quiet_a: assert property (wr && addr == `MPT_ADDR_SWRST && wdata[0] |-> ##3 (!irq && chan_pre == 0))
      else $error("software reset left activity");
   enable_off_a: assert property (wr && addr == `MPT_ADDR_IRQEN && wdata[NCH-1:0] == 0 |-> ##3 !irq)
      else $error("irq with all enables off");
   // Software reset clears flags one cycle later than a clear or enable write
   irq_fall_a: assert property ($fell(irq) |-> $past(wr, 2) || $past(wr, 3))
      else $error("irq fell without a write");
   // Expiry pulse stands one cycle before the level rises
   irq_rise_a: assert property ($rose(irq) |-> $past(chan_trig) != 0 || $past(wr, 2))
      else $error("irq rose without cause");
   trig_pulse_a: assert property ((chan_trig & $past(chan_trig)) == 0)
      else $error("expiry pulse too long");
   c_expire: cover property (chan_trig[0]);
   c_irq: cover property ($rose(irq));
   c_pre: cover property ($rose(chan_pre[1]));
endmodule
bind mpt_timer mpt_sva #(.NCH(NCH), .NSRC(NSRC), .ID_VALUE(ID_VALUE)) u_sva (.clk(clk), .rst_b(rst_b),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_trig(ext_trig), .debug_mode(debug_mode),
   .doze_mode(doze_mode), .chan_trig(chan_trig), .chan_pre(chan_pre), .irq(irq));
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "mpt_defines.vh"
module testbench;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, dbg = 0, doze = 0;
   logic [7:0] addr = 0;
   logic [31:0] wdata = 0;
   logic [15:0] ext = 0;
   wire [31:0] rdata;
   wire [3:0] ctrig, cpre;
   wire irq;
   int n_fail = 0, comparisons = 0, k;
   always #5 clk = ~clk;
   mpt_timer #(.NCH(4), .NSRC(16), .ID_VALUE(32'h00001234)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_trig(ext), .debug_mode(dbg), .doze_mode(doze),
      .chan_trig(ctrig), .chan_pre(cpre), .irq(irq));
   function automatic logic [7:0] ca(input int n, r);
      return 8'(32'h20 + 16 * n + 4 * r);
   endfunction
   task automatic chk(input logic [31:0] seen, exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // Read data is sampled at the edge after the strobe
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk(rdata, exp, what);
   endtask
   task automatic gap(input int ch, output int g);
      k = 0;
      do @(posedge clk); while (ctrig[ch] !== 1'b1 && ++k < 300);
      g = 0;
      do begin
         @(posedge clk);
         g++;
      end while (ctrig[ch] !== 1'b1 && g < 300);
   endtask
   task automatic cnt(input int ch, input int n, output int p);
      p = 0;
      repeat (n) begin
         @(posedge clk);
         if (ctrig[ch] === 1'b1) p++;
      end
   endtask
   task automatic tp(input int b);
      ext[b] <= 1'b1;
      repeat (2) @(posedge clk);
      ext[b] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #300000;
      n_fail++;
      end_of_test;
   end
   initial begin
      int g, p;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(`MPT_ADDR_MCTRL, 0, "mctrl");
      rdc(`MPT_ADDR_STATUS, 0, "status");
      rdc(8'hfc, 0, "hole");
      rdc(`MPT_ADDR_ID, 32'h1234, "id");
      wrr(`MPT_ADDR_MCTRL, 32'h4);
      repeat (`MPT_SETTLE_CYC) @(posedge clk);
      wrr(`MPT_ADDR_IRQEN, 32'h5);
      rdc(`MPT_ADDR_IRQEN, 32'h5, "irqen");
      wrr(`MPT_ADDR_IRQEN, 32'h0);
      wrr(ca(0, 0), 32'd9);
      wrr(ca(0, 2), 32'h1);
      gap(0, g);
      chk(g, 10, "full gap");
      wrr(ca(0, 0), 32'd4);
      gap(0, g);
      chk(g, 5, "new period");
      rdc(`MPT_ADDR_STATUS, 1, "flag");
      chk(cpre, 0, "no pre");
      wrr(`MPT_ADDR_IRQEN, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 1, "irq on");
      wrr(ca(0, 2), 32'h0);
      wrr(`MPT_ADDR_CLEAR, 32'he);
      chk(irq, 1, "clear zero");
      wrr(`MPT_ADDR_CLEAR, 32'h1);
      repeat (3) @(posedge clk);
      chk(irq, 0, "irq off");
      wrr(ca(0, 0), 32'd3);
      wrr(ca(0, 2), 32'h21);
      cnt(0, 40, p);
      chk(p, 1, "halt");
      // Debug then doze freeze, then the matching run-through bit
      for (int m = 0; m < 2; m++) begin
         wrr(`MPT_ADDR_MCTRL, 32'h4);
         dbg <= (m == 0);
         doze <= (m == 1);
         wrr(ca(0, 2), 32'h0);
         wrr(ca(0, 2), 32'h1);
         cnt(0, 30, p);
         chk(p, 0, "frozen");
         wrr(`MPT_ADDR_MCTRL, 32'h4 | (32'h1 << m));
         cnt(0, 30, p);
         chk(p > 6, 1, "runs");
      end
      dbg <= 1'b0;
      doze <= 1'b0;
      wrr(ca(3, 0), 32'd1);
      wrr(ca(3, 2), 32'h15);
      gap(3, g);
      chk(g, 8, "inside trig");
      wrr(ca(2, 0), 32'd2);
      wrr(ca(2, 2), 32'h305);
      tp(3);
      tp(3);
      rdc(ca(2, 1), 1, "trig count");
      tp(5);
      rdc(ca(2, 1), 1, "unselected");
      wrr(ca(1, 0), 32'h00010002);
      wrr(ca(1, 2), 32'h3);
      k = 0;
      do @(posedge clk); while (cpre[1] !== 1'b1 && ++k < 100);
      chk(ctrig[1], 0, "pre first");
      k = 0;
      do @(posedge clk); while (ctrig[1] !== 1'b1 && ++k < 100);
      // Pre-trigger drops in the same cycle as the expiry pulse
      chk(cpre[1], 0, "pre falls");
      chk(k < 100, 1, "split expiry");
      // Capture one step after the all-ones load
      wrr(ca(1, 2), 32'h0);
      wrr(ca(1, 2), 32'h707);
      tp(7);
      rdc(ca(1, 3), 32'h1, "capture");
      wrr(ca(1, 2), 32'h0);
      wrr(ca(1, 0), 32'd1);
      wrr(ca(1, 2), 32'h9);
      gap(1, g);
      chk(g, 8, "chained");
      wrr(ca(2, 2), 32'h0);
      wrr(ca(2, 0), 32'd100);
      wrr(ca(2, 2), 32'h3c1);
      rdc(ca(2, 1), 32'd100, "start wait");
      tp(3);
      rdc(ca(2, 1), 32'd96, "started");
      tp(3);
      rdc(ca(2, 1), 32'd96, "trig reload");
      wrr(`MPT_ADDR_SWRST, 32'h1);
      repeat (`MPT_SETTLE_CYC) @(posedge clk);
      rdc(`MPT_ADDR_MCTRL, 32'h6, "mctrl kept");
      rdc(`MPT_ADDR_IRQEN, 0, "irqen reset");
      rdc(`MPT_ADDR_STATUS, 0, "flags reset");
      rdc(ca(0, 0), 0, "period reset");
      end_of_test;
   end
endmodule
`default_nettype wire
